// file: src/atc_pkg.sv
// Purpose: Shared constants for the acquisition and trigger control bank
// Assumes: APB slave with 32-bit data, one aligned word per register
// Notes:   Offsets are byte addresses on the APB bus

package atc_pkg;

  // ************************************************************
  // Register offsets
  // ************************************************************
  localparam logic [15:0] OFS_BUFFER_RELEASE  = 16'h8010;
  localparam logic [15:0] OFS_EVENT_SIZE      = 16'h8020;
  localparam logic [15:0] OFS_RUN_CONTROL     = 16'h8100;
  localparam logic [15:0] OFS_RUN_STATUS      = 16'h8104;
  localparam logic [15:0] OFS_SOFT_TRIGGER    = 16'h8108;
  localparam logic [15:0] OFS_TRIGGER_SOURCE  = 16'h810C;
  localparam logic [15:0] OFS_RELEASE_STATUS  = 16'h8030;
  localparam logic [15:0] OFS_PERSIST_COUNT   = 16'h8034;
  localparam logic [15:0] OFS_TRIGGER_COUNT   = 16'h8038;
  localparam logic [15:0] OFS_OCCUPANCY       = 16'h803C;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int CTRL_COUNT_ALL  = 3;
  localparam int CTRL_RUN        = 2;
  localparam int STAT_READY      = 8;
  localparam int STAT_PLL_OK     = 7;
  localparam int STAT_BYPASS     = 6;
  localparam int STAT_EXT_CLK    = 5;
  localparam int STAT_FULL       = 4;
  localparam int STAT_EV_READY   = 3;
  localparam int STAT_RUN        = 2;
  localparam int SRC_SW_EN       = 31;
  localparam int SRC_EXT_EN      = 30;
  localparam int SRC_COINC_LO    = 24;
  localparam int REL_ERR_BIT     = 5;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [2:0]  RST_COINC   = 3'h0;
  localparam logic [11:0] RST_PERSIST = 12'h000;
  localparam logic        RST_PLL_OK  = 1'b1;
  localparam logic        RST_GATE    = 1'b1;

  typedef enum logic [1:0] {
    ATC_MODE_REG      = 2'b00,
    ATC_MODE_SIN_RUN  = 2'b01,
    ATC_MODE_SIN_GATE = 2'b10,
    ATC_MODE_SYNC     = 2'b11
  } atc_mode_t;

endpackage : atc_pkg

// file: src/atc_regs.sv
// Purpose: Acquisition and trigger control register bank with APB access
// Assumes: All inputs synchronous to CLK_SYS; one event per EVENT_DONE pulse
// Notes:   APB answers with no wait state; all outputs come from flops
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none

module atc_regs #(
  parameter int NUM_CH     = 8,
  parameter int MAX_EVENTS = 1024,
  parameter int LOC_W      = 20
) (
  input  wire logic                CLK_SYS,
  input  wire logic                SYS_RST,
  input  wire logic                PSEL,
  input  wire logic                PENABLE,
  input  wire logic                PWRITE,
  input  wire logic [15:0]         PADDR,
  input  wire logic [31:0]         PWDATA,
  output var  logic [31:0]         PRDATA,
  output var  logic                PREADY,
  output var  logic                PSLVERR,
  input  wire logic                BOARD_READY,
  input  wire logic                PLL_LOCK,
  input  wire logic                PLL_BYPASS,
  input  wire logic                CLK_EXT_SEL,
  input  wire logic                SYNC_IN,
  input  wire logic                EXTERNAL_TRIGGER_INPUT,
  input  wire logic [NUM_CH-1:0]   OVER_THR,
  input  wire logic                ACQ_BUSY,
  input  wire logic                EVENT_DONE,
  input  wire logic                PACKED_SAMPLE_MODE,
  output var  logic                RUN_ACTIVE,
  output var  logic                GATE_OPEN,
  output var  logic                TRIGGER,
  output var  logic                MEM_RESET,
  output var  logic                COUNT_ALL,
  output var  logic                SIZE_EN,
  output var  logic [LOC_W-1:0]    LOCATIONS_PER_EVENT,
  output var  logic [LOC_W+1:0]    EVENT_SAMPLES,
  output var  logic                RELEASE_STB,
  output var  logic [11:0]         RELEASE_COUNT
);

  localparam int OCC_W = $clog2(MAX_EVENTS + 1);

  // ************************************************************
  // Elaboration checks
  // ************************************************************
  if (NUM_CH < 1 || NUM_CH > 8) begin : g_bad_ch
    $error("NUM_CH must lie in 1..8");
  end
  if (MAX_EVENTS < 1 || MAX_EVENTS > 4095) begin : g_bad_ev
    $error("MAX_EVENTS must lie in 1..4095");
  end
  if (LOC_W < 1 || LOC_W > 29) begin : g_bad_loc
    $error("LOC_W must lie in 1..29");
  end

  typedef struct packed {
    logic                         pready;
    logic                         pslverr;
    logic [31:0]                  prdata;
    logic [11:0]                  rel_n;
    logic                         rel_stb;
    logic                         rel_err;
    logic [LOC_W-1:0]             size;
    logic                         size_en;
    logic [LOC_W+1:0]             samples;
    logic                         count_all;
    logic                         run_bit;
    atc_pkg::atc_mode_t           mode;
    logic                         running;
    logic                         gate;
    logic                         mem_rst;
    logic                         pll_ok;
    logic                         rdy;
    logic                         byp;
    logic                         ext_clk;
    logic [OCC_W-1:0]             occ;
    logic [NUM_CH-1:0]            trig_mask;
    logic [2:0]                   coinc;
    logic                         ext_en;
    logic                         sw_en;
    logic [11:0]                  persist;
    logic [NUM_CH-1:0][11:0]      hold;
    logic [NUM_CH-1:0]            qual;
    logic                         sync_prev;
    logic                         ext_prev;
    logic                         trig;
    logic [31:0]                  trig_cnt;
  } atc_state_t;

  atc_state_t s;
  atc_state_t next_s;

  logic [NUM_CH-1:0][11:0] next_hold;
  logic [NUM_CH-1:0]       next_qual;
  logic [NUM_CH-1:0]       ch_fire;

  // ************************************************************
  // Per-channel persistence qualifier
  // ************************************************************
  // Qualifying after the count has elapsed is what delays the local
  // trigger by the same count.
  for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
    assign next_hold[i] = !OVER_THR[i] ? 12'h000 :
                          (s.hold[i] >= s.persist) ? s.hold[i] :
                          s.hold[i] + 12'h001;
    assign next_qual[i] = OVER_THR[i] && (s.hold[i] >= s.persist);
    assign ch_fire[i]   = next_qual[i] && !s.qual[i]
                          && s.trig_mask[i];
  end

  // ************************************************************
  // Next-state logic
  // ************************************************************
  logic             setup;
  logic             wr;
  logic             rd;
  logic             hit;
  logic [31:0]      status;
  logic [31:0]      rmux;
  logic             sw_hit;
  logic             ext_hit;
  logic             loc_hit;
  logic             any_trig;
  logic             sync_rise;
  logic             ev_full;
  logic [LOC_W+2:0] x5;

  always_comb begin
    next_s    = s;
    setup     = PSEL && !PENABLE;
    wr        = PSEL && PENABLE && s.pready && PWRITE;
    rd        = PSEL && PENABLE && s.pready && !PWRITE;
    ev_full   = (int'(s.occ) == MAX_EVENTS);
    sync_rise = SYNC_IN && !s.sync_prev;

    status = 32'h0;
    status[atc_pkg::STAT_READY]    = s.rdy;
    status[atc_pkg::STAT_PLL_OK]   = s.pll_ok;
    status[atc_pkg::STAT_BYPASS]   = s.byp;
    status[atc_pkg::STAT_EXT_CLK]  = s.ext_clk;
    status[atc_pkg::STAT_FULL]     = ev_full;
    status[atc_pkg::STAT_EV_READY] = (s.occ != '0);
    status[atc_pkg::STAT_RUN]      = s.running;

    hit  = 1'b1;
    rmux = 32'h0;
    unique case (PADDR)
      atc_pkg::OFS_BUFFER_RELEASE: rmux[11:0] = s.rel_n;
      atc_pkg::OFS_EVENT_SIZE:     rmux[LOC_W-1:0] = s.size;
      atc_pkg::OFS_RUN_CONTROL: begin
        rmux[atc_pkg::CTRL_COUNT_ALL] = s.count_all;
        rmux[atc_pkg::CTRL_RUN]       = s.run_bit;
        rmux[1:0]                     = s.mode;
      end
      atc_pkg::OFS_RUN_STATUS:     rmux = status;
      atc_pkg::OFS_SOFT_TRIGGER:   rmux = 32'h0;
      atc_pkg::OFS_TRIGGER_SOURCE: begin
        rmux[atc_pkg::SRC_SW_EN]  = s.sw_en;
        rmux[atc_pkg::SRC_EXT_EN] = s.ext_en;
        rmux[atc_pkg::SRC_COINC_LO +: 3] = s.coinc;
        rmux[NUM_CH-1:0] = s.trig_mask;
      end
      atc_pkg::OFS_RELEASE_STATUS: rmux[atc_pkg::REL_ERR_BIT] = s.rel_err;
      atc_pkg::OFS_PERSIST_COUNT:  rmux[11:0] = s.persist;
      atc_pkg::OFS_TRIGGER_COUNT:  rmux = s.trig_cnt;
      atc_pkg::OFS_OCCUPANCY:      rmux[OCC_W-1:0] = s.occ;
      default:                     hit = 1'b0;
    endcase

    // Bus answer prepared in the setup cycle, no wait state
    next_s.pready  = setup;
    next_s.pslverr = setup && !hit;
    next_s.prdata  = setup ? rmux : 32'h0;

    next_s.rdy     = BOARD_READY;
    next_s.byp     = PLL_BYPASS;
    next_s.ext_clk = CLK_EXT_SEL;
    // Loss of lock wins over a restoring status read
    if (!PLL_LOCK) begin
      next_s.pll_ok = 1'b0;
    end else if (rd && PADDR == atc_pkg::OFS_RUN_STATUS) begin
      next_s.pll_ok = 1'b1;
    end

    next_s.rel_stb = 1'b0;
    next_s.mem_rst = 1'b0;
    sw_hit         = 1'b0;

    // Events land only while running and never beyond the capacity
    if (EVENT_DONE && s.running && !ev_full) begin
      next_s.occ = s.occ + OCC_W'(1);
    end

    if (rd && PADDR == atc_pkg::OFS_RELEASE_STATUS) begin
      next_s.rel_err = 1'b0;
    end

    if (wr) begin
      unique case (PADDR)
        atc_pkg::OFS_BUFFER_RELEASE: begin
          next_s.rel_n = PWDATA[11:0];
          if (int'(PWDATA[11:0]) > int'(next_s.occ)) begin
            next_s.rel_err = 1'b1;
          end else begin
            next_s.occ     = next_s.occ - OCC_W'(PWDATA[11:0]);
            next_s.rel_stb = 1'b1;
          end
        end
        // Changing the size mid-run is the host's fault, not checked
        atc_pkg::OFS_EVENT_SIZE: next_s.size = PWDATA[LOC_W-1:0];
        atc_pkg::OFS_RUN_CONTROL: begin
          next_s.count_all = PWDATA[atc_pkg::CTRL_COUNT_ALL];
          next_s.run_bit   = PWDATA[atc_pkg::CTRL_RUN];
          next_s.mode      = atc_pkg::atc_mode_t'(PWDATA[1:0]);
          if (PWDATA[atc_pkg::CTRL_RUN] && !s.run_bit) begin
            next_s.mem_rst = 1'b1;
            next_s.occ     = '0;
          end
        end
        atc_pkg::OFS_SOFT_TRIGGER: sw_hit = s.sw_en;
        atc_pkg::OFS_TRIGGER_SOURCE: begin
          next_s.sw_en     = PWDATA[atc_pkg::SRC_SW_EN];
          next_s.ext_en    = PWDATA[atc_pkg::SRC_EXT_EN];
          next_s.coinc     = PWDATA[atc_pkg::SRC_COINC_LO +: 3];
          next_s.trig_mask = PWDATA[NUM_CH-1:0];
        end
        atc_pkg::OFS_PERSIST_COUNT: next_s.persist = PWDATA[11:0];
        default: ;
      endcase
    end

    // Run and gate per run mode; clearing the run bit never touches
    // the occupancy, so stored events stay readable
    unique case (next_s.mode)
      atc_pkg::ATC_MODE_REG: begin
        next_s.running = next_s.run_bit;
        next_s.gate    = 1'b1;
      end
      atc_pkg::ATC_MODE_SIN_RUN: begin
        next_s.running = next_s.run_bit
                         && (s.running || sync_rise);
        next_s.gate    = 1'b1;
      end
      atc_pkg::ATC_MODE_SIN_GATE: begin
        next_s.running = next_s.run_bit;
        next_s.gate    = SYNC_IN;
      end
      atc_pkg::ATC_MODE_SYNC: begin
        // Synchronisation is handled outside; here it acts like mode 00
        next_s.running = next_s.run_bit;
        next_s.gate    = 1'b1;
      end
    endcase

    next_s.sync_prev = SYNC_IN;
    next_s.ext_prev  = EXTERNAL_TRIGGER_INPUT;
    next_s.hold      = next_hold;
    next_s.qual      = next_qual;

    ext_hit = EXTERNAL_TRIGGER_INPUT && !s.ext_prev && s.ext_en;
    loc_hit = (ch_fire != '0) && ($countones(next_qual & s.trig_mask)
              > int'(s.coinc));
    any_trig = (sw_hit || ext_hit || loc_hit)
               && s.running && s.gate;
    next_s.trig = any_trig;
    if (any_trig && (s.count_all || !ACQ_BUSY)) begin
      next_s.trig_cnt = s.trig_cnt + 32'h1;
    end

    x5 = ({3'b000, next_s.size} << 2) + {3'b000, next_s.size};
    next_s.samples = PACKED_SAMPLE_MODE ? x5[LOC_W+2:1]
                   : {1'b0, next_s.size, 1'b0};
    // Kept in a flop so the enable leaves the block registered
    next_s.size_en = (next_s.size != '0);
  end

  // ************************************************************
  // State register
  // ************************************************************
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      s         <= '0;
      s.pll_ok  <= atc_pkg::RST_PLL_OK;
      s.coinc   <= atc_pkg::RST_COINC;
      s.persist <= atc_pkg::RST_PERSIST;
      // Mode 00 is the reset mode, so the gate starts open
      s.gate    <= atc_pkg::RST_GATE;
    end else begin
      s <= next_s;
    end
  end

  assign PRDATA              = s.prdata;
  assign PREADY              = s.pready;
  assign PSLVERR             = s.pslverr;
  assign RUN_ACTIVE          = s.running;
  assign GATE_OPEN           = s.gate;
  assign TRIGGER             = s.trig;
  assign MEM_RESET           = s.mem_rst;
  assign COUNT_ALL           = s.count_all;
  assign SIZE_EN             = s.size_en;
  assign LOCATIONS_PER_EVENT = s.size;
  assign EVENT_SAMPLES       = s.samples;
  assign RELEASE_STB         = s.rel_stb;
  assign RELEASE_COUNT       = s.rel_n;

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (SYS_RST);

  sequence sw_write_s;
    PSEL && PENABLE && PREADY && PWRITE
      && PADDR == atc_pkg::OFS_SOFT_TRIGGER;
  endsequence
  sequence run_set_s;
    PSEL && PENABLE && PREADY && PWRITE && !s.run_bit
      && PADDR == atc_pkg::OFS_RUN_CONTROL && PWDATA[2];
  endsequence
  sequence ext_rise_s;
    !EXTERNAL_TRIGGER_INPUT ##1 EXTERNAL_TRIGGER_INPUT;
  endsequence

  chk_sw_trig_gen: assert property (
    sw_write_s ##0 (s.sw_en && s.running && s.gate) |=> TRIGGER)
    else $error("software trigger write gave no trigger");
  chk_stop_ignores: assert property (
    !RUN_ACTIVE |=> !TRIGGER)
    else $error("trigger while stopped");
  chk_run_memrst: assert property (
    run_set_s |=> MEM_RESET && s.occ == '0)
    else $error("run set without memory reset");
  chk_stop_keeps: assert property (
    $fell(s.run_bit) |-> s.occ == $past(s.occ))
    else $error("stop lost stored events");
  chk_gate_open: assert property (
    s.mode != atc_pkg::ATC_MODE_SIN_GATE |-> GATE_OPEN)
    else $error("gate closed outside gate mode");
  chk_gate_sync: assert property (
    (s.mode == atc_pkg::ATC_MODE_SIN_GATE)[*2] |-> GATE_OPEN == $past(SYNC_IN))
    else $error("gate does not follow sync input");
  chk_pll_sticky: assert property (
    !PLL_LOCK || (!s.pll_ok && !(PSEL && PENABLE && PREADY && !PWRITE
      && PADDR == atc_pkg::OFS_RUN_STATUS)) |=> !s.pll_ok)
    else $error("lock flag not held low after loss");
  chk_ready_bit: assert property (
    ##1 s.rdy == $past(BOARD_READY))
    else $error("ready bit does not track board ready");
  chk_rel_error: assert property (
    PSEL && PENABLE && PREADY && PWRITE && !EVENT_DONE
      && PADDR == atc_pkg::OFS_BUFFER_RELEASE
      && int'(PWDATA[11:0]) > int'(s.occ) |=> s.rel_err && !RELEASE_STB)
    else $error("over-release did not flag an error");
  chk_ext_trig_gen: assert property (
    ext_rise_s ##0 (s.ext_en && RUN_ACTIVE && GATE_OPEN) |=> TRIGGER)
    else $error("enabled external trigger edge gave no trigger");
  chk_mem_single: assert property (
    MEM_RESET |=> !MEM_RESET)
    else $error("memory reset pulse longer than one cycle");
  chk_rel_count: assert property (
    PSEL && PENABLE && PREADY && PWRITE && !EVENT_DONE
      && PADDR == atc_pkg::OFS_BUFFER_RELEASE
      && int'(PWDATA[11:0]) <= int'(s.occ)
      |=> RELEASE_STB
      && int'(s.occ) == int'($past(s.occ)) - int'($past(PWDATA[11:0])))
    else $error("buffer release did not free the blocks");
  chk_plain_samples: assert property (
    !PACKED_SAMPLE_MODE
      |=> int'(EVENT_SAMPLES) == 2 * int'(LOCATIONS_PER_EVENT))
    else $error("samples per event not twice the locations");

endmodule : atc_regs

`default_nettype wire

// file: verif/acquisition_trigger_control_regs_bench.sv
// Purpose: Self-checking bench for the acquisition and trigger control bank
// Assumes: APB answers within the bench timeout; MAX_EVENTS set small
// Notes:   Trigger and memory reset pulses are counted by monitors
`timescale 1ns/10ps
`default_nettype none

module acquisition_trigger_control_regs_bench;
  // ************************************************************
  // Signals
  // ************************************************************
  logic        clk, rst, psel, penable, pwrite, err, brd, pll, byp, ext;
  logic        sync_in, external_trigger_input, busy, ev_done, packed_mode, pready, pslverr;
  logic        run_active, gate_open, trigger, mem_reset, count_all, size_en;
  logic        release_stb;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata, rd, v;
  logic [7:0]  over;
  logic [19:0] locs;
  logic [21:0] samples;
  logic [11:0] release_count;
  integer      miscompares, total_checks, trig_n, mem_n, t0, cyc, seed, i;
  integer      rel_cnt;

  atc_regs #(.NUM_CH(8), .MAX_EVENTS(3), .LOC_W(20)) dut_u (
    .CLK_SYS(clk), .SYS_RST(rst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .BOARD_READY(brd), .PLL_LOCK(pll),
    .PLL_BYPASS(byp), .CLK_EXT_SEL(ext), .SYNC_IN(sync_in),
    .EXTERNAL_TRIGGER_INPUT(external_trigger_input), .OVER_THR(over), .ACQ_BUSY(busy),
    .EVENT_DONE(ev_done), .PACKED_SAMPLE_MODE(packed_mode),
    .RUN_ACTIVE(run_active), .GATE_OPEN(gate_open), .TRIGGER(trigger),
    .MEM_RESET(mem_reset), .COUNT_ALL(count_all), .SIZE_EN(size_en),
    .LOCATIONS_PER_EVENT(locs), .EVENT_SAMPLES(samples),
    .RELEASE_STB(release_stb), .RELEASE_COUNT(release_count));

  // ************************************************************
  // Clock, monitors and timeout
  // ************************************************************
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Pulses are counted rather than timed, so latency choices cannot mislead
  always @(posedge clk) begin
    if (trigger === 1'b1) trig_n = trig_n + 1;
    if (mem_reset === 1'b1) mem_n = mem_n + 1;
    if (release_stb === 1'b1) rel_cnt = rel_cnt + 1;
    cyc = cyc + 1;
    if (cyc > 20000) begin
      miscompares = miscompares + 1;
      summarize();
    end
  end

  // ************************************************************
  // Tasks and expectation functions
  // ************************************************************
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : summarize

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks = total_checks + 1;
    if (got !== exp) begin
      miscompares = miscompares + 1;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask : idle

  // Holds the request until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [15:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n = n + 1;
    end while (!(pready === 1'b1 && psel && penable) && n < 50);
    rd  = prdata;
    err = pslverr;
    if (n >= 50) begin
      chk(32'hDEAD, 32'h0);
      summarize();
    end
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic dtrig(input logic [31:0] e);
    idle(6);
    chk(trig_n - t0, e);
    t0 = trig_n;
  endtask : dtrig

  function automatic logic [31:0] st(input logic pk, full, evr, run);
    return {23'h0, brd, pk, byp, ext, full, evr, run, 2'b00};
  endfunction : st

  function automatic logic [21:0] smp(input logic [19:0] n, input logic p);
    logic [23:0] x;
    x = {4'h0, n} * 24'h5;
    return p ? x[22:1] : {1'b0, n, 1'b0};
  endfunction : smp

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    miscompares = 0; total_checks = 0; trig_n = 0; mem_n = 0; cyc = 0;
    seed = 13; rel_cnt = 0;
    brd = 1'($random(seed));
    byp = 1'($random(seed));
    ext = 1'($random(seed));
    rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 16'h0; pwdata = 32'h0; pll = 1'b1; sync_in = 1'b0;
    external_trigger_input = 1'b0; busy = 1'b0; ev_done = 1'b0; packed_mode = 1'b0;
    over = 8'h00;
    idle(4);
    rst <= 1'b0;
    idle(2);
    apb(1'b0, atc_pkg::OFS_RUN_STATUS, 32'h0);
    chk(rd, st(1'b1, 1'b0, 1'b0, 1'b0));
    apb(1'b0, 16'h8040, 32'h0);
    chk({err, rd[30:0]}, 32'h8000_0000);
    // Size: zero (plain mode), full-scale (packed mode) and random values in both sample modes
    for (i = 0; i < 5; i++) begin
      v = (i == 0) ? 32'h0 : (i == 1) ? 32'h000F_FFFF
                           : ($random(seed) & 32'h000F_FFFF);
      packed_mode <= i[0];
      apb(1'b1, atc_pkg::OFS_EVENT_SIZE, v);
      idle(2);
      chk(size_en, (v != 0));
      chk(locs, v);
      chk(samples, smp(v[19:0], i[0]));
    end
    // Stopped board ignores an enabled software trigger
    t0 = trig_n;
    apb(1'b1, atc_pkg::OFS_TRIGGER_SOURCE, 32'h8000_0000);
    apb(1'b1, atc_pkg::OFS_SOFT_TRIGGER, 32'h0);
    dtrig(0);
    brd <= 1'b1;
    do begin
      apb(1'b0, atc_pkg::OFS_RUN_STATUS, 32'h0);
    end while (rd[8] !== 1'b1);
    apb(1'b1, atc_pkg::OFS_RUN_CONTROL, 32'h0000_000C);
    idle(3);
    chk(mem_n, 1);
    chk({run_active, gate_open, count_all}, 3'h7);
    apb(1'b1, atc_pkg::OFS_SOFT_TRIGGER, $random(seed));
    dtrig(1);
    apb(1'b1, atc_pkg::OFS_TRIGGER_SOURCE, 32'h0000_0000);
    apb(1'b1, atc_pkg::OFS_SOFT_TRIGGER, $random(seed));
    dtrig(0);
    external_trigger_input <= 1'b1;
    idle(2);
    external_trigger_input <= 1'b0;
    dtrig(0);
    apb(1'b1, atc_pkg::OFS_TRIGGER_SOURCE, 32'h4000_0000);
    external_trigger_input <= 1'b1;
    idle(2);
    external_trigger_input <= 1'b0;
    dtrig(1);
    // Coincidence level one needs a second masked channel over threshold
    apb(1'b1, atc_pkg::OFS_TRIGGER_SOURCE, 32'h0100_0003);
    over <= 8'h01;
    dtrig(0);
    over <= 8'h03;
    dtrig(1);
    over <= 8'h00;
    apb(1'b1, atc_pkg::OFS_TRIGGER_SOURCE, 32'h0000_0004);
    over <= 8'h08;
    dtrig(0);
    over <= 8'h04;
    dtrig(1);
    over <= 8'h00;
    // Three events fill the small store; stopping keeps them readable
    repeat (3) begin
      ev_done <= 1'b1;
      idle(1);
      ev_done <= 1'b0;
      idle(1);
    end
    idle(2);
    apb(1'b0, atc_pkg::OFS_RUN_STATUS, 32'h0);
    chk(rd, st(1'b1, 1'b1, 1'b1, 1'b1));
    apb(1'b1, atc_pkg::OFS_RUN_CONTROL, 32'h0000_0008);
    idle(2);
    apb(1'b0, atc_pkg::OFS_RUN_STATUS, 32'h0);
    chk(rd, st(1'b1, 1'b1, 1'b1, 1'b0));
    apb(1'b1, atc_pkg::OFS_BUFFER_RELEASE, 32'h1);
    apb(1'b0, atc_pkg::OFS_OCCUPANCY, 32'h0);
    chk(rd, 32'h2);
    chk(rel_cnt, 1);
    chk(release_count, 32'h1);
    apb(1'b1, atc_pkg::OFS_BUFFER_RELEASE, 32'h5);
    apb(1'b0, atc_pkg::OFS_RELEASE_STATUS, 32'h0);
    chk(rd[5], 1'b1);
    apb(1'b0, atc_pkg::OFS_OCCUPANCY, 32'h0);
    chk(rd, 32'h2);
    chk(rel_cnt, 1);
    // Mode 01 waits for a sync rising edge before running
    apb(1'b1, atc_pkg::OFS_RUN_CONTROL, 32'h0000_0005);
    idle(4);
    chk(run_active, 1'b0);
    sync_in <= 1'b1;
    idle(4);
    chk({run_active, gate_open}, 2'h3);
    sync_in <= 1'b0;
    // Mode 10 uses the sync input as the gate
    apb(1'b1, atc_pkg::OFS_RUN_CONTROL, 32'h0000_0000);
    apb(1'b1, atc_pkg::OFS_TRIGGER_SOURCE, 32'h8000_0000);
    apb(1'b1, atc_pkg::OFS_RUN_CONTROL, 32'h0000_0006);
    idle(3);
    chk({run_active, gate_open}, 2'h2);
    t0 = trig_n;
    apb(1'b1, atc_pkg::OFS_SOFT_TRIGGER, 32'h0);
    dtrig(0);
    sync_in <= 1'b1;
    idle(3);
    chk(gate_open, 1'b1);
    apb(1'b1, atc_pkg::OFS_SOFT_TRIGGER, 32'h0);
    dtrig(1);
    apb(1'b1, atc_pkg::OFS_RUN_CONTROL, 32'h0000_0000);
    apb(1'b1, atc_pkg::OFS_RUN_CONTROL, 32'h0000_0007);
    idle(3);
    chk({run_active, gate_open}, 2'h3);
    // Lost lock stays flagged until a status read while locked
    pll <= 1'b0;
    idle(3);
    pll <= 1'b1;
    idle(3);
    apb(1'b0, atc_pkg::OFS_RUN_STATUS, 32'h0);
    chk(rd[7], 1'b0);
    apb(1'b0, atc_pkg::OFS_RUN_STATUS, 32'h0);
    chk(rd[7:5], {1'b1, byp, ext});
    // Bit 3 clear: a trigger while busy is issued but not counted
    apb(1'b0, atc_pkg::OFS_TRIGGER_COUNT, 32'h0);
    v = rd;
    t0 = trig_n;
    busy <= 1'b1;
    apb(1'b1, atc_pkg::OFS_SOFT_TRIGGER, $random(seed));
    dtrig(1);
    apb(1'b0, atc_pkg::OFS_TRIGGER_COUNT, 32'h0);
    chk(rd, v);
    apb(1'b1, atc_pkg::OFS_RUN_CONTROL, 32'h0000_000F);
    apb(1'b1, atc_pkg::OFS_SOFT_TRIGGER, $random(seed));
    dtrig(1);
    busy <= 1'b0;
    apb(1'b1, atc_pkg::OFS_RUN_CONTROL, 32'h0000_0007);
    apb(1'b1, atc_pkg::OFS_SOFT_TRIGGER, $random(seed));
    dtrig(1);
    apb(1'b0, atc_pkg::OFS_TRIGGER_COUNT, 32'h0);
    chk(rd, v + 32'h2);
    // Persistence 3: a masked channel needs four samples over threshold
    apb(1'b1, atc_pkg::OFS_PERSIST_COUNT, 32'h3);
    apb(1'b1, atc_pkg::OFS_TRIGGER_SOURCE, 32'h0000_0002);
    over <= 8'h02;
    idle(3);
    over <= 8'h00;
    dtrig(0);
    over <= 8'h02;
    idle(3);
    chk(trig_n - t0, 0);
    dtrig(1);
    over <= 8'h00;
    summarize();
  end
endmodule : acquisition_trigger_control_regs_bench

`default_nettype wire
